// ===== common/usb_sel_cfg.svh
// Purpose: offsets, fields, reset values and timing for the USB select/suspend block
// Assumes: 40 MHz system clock
// Notes:   byte address of a register is four times its index
`ifndef USB_SEL_CFG_SVH
`define USB_SEL_CFG_SVH

`define HTS_IDX       12'h1F9
`define PIN_IDX       12'h250
`define CTRL_IDX      12'h300
`define STAT_IDX      12'h301
`define ISTAT_IDX     12'h302
`define IMASK_IDX     12'h303
`define REG_ADDR(idx) {idx, 2'b00}

`define HTS_RESET     16'h0001
`define HTS_SERIAL    16'h0001
`define HTS_USB       16'h0002
`define PIN_RESET     16'hFFFF
`define PIN_MAX       16'h000F

`define CTRL_BOOT     0
`define CTRL_CFG      1
`define CTRL_RWEN     2
`define CTRL_WAKE     3
`define ST_SUSP       0
`define ST_USB        1
`define ST_LOCK       2
`define ST_DRIVE      3
`define IRQ_SUSP      0
`define IRQ_RES       1
`define IRQ_LOCK      2
`define IRQ_BITS      3

`define CLK_PERIOD_NS 25
`define IDLE_MIN_US   3000
`define SUSP_MAX_US   10000
`define RESUME_US     2000
`define IDLE_MIN_CYC  ((`IDLE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSP_MAX_CYC  ((`SUSP_MAX_US * 1000) / `CLK_PERIOD_NS)
`define RESUME_CYC    ((`RESUME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== common/usb_sel_pkg.sv
// Purpose: types of the USB select/suspend block
// Assumes: nothing
// Notes:   state codes written out
package usb_sel_pkg;
	typedef enum logic [1:0] {
		TRK_ACTIVE    = 2'b00,
		TRK_SUSPENDED = 2'b01,
		TRK_WAKE      = 2'b10
	} trk_state_type;
	typedef enum logic {
		SEL_WAIT   = 1'b0,
		SEL_LOCKED = 1'b1
	} sel_state_type;
endpackage

// ===== common/usb_ctl_if.sv
// Purpose: carrier between the top and its two helpers
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface usb_ctl_if;
	logic        boot_go;
	logic [15:0] hts_key;
	logic [15:0] pin_key;
	logic        use_usb;
	logic        locked;
	logic [2:0]  irq_set;
	logic [2:0]  irq_w1c;
	logic        mask_wr;
	logic [2:0]  mask_wdata;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic        irq;
	modport top_mp (output boot_go, hts_key, pin_key, irq_set, irq_w1c, mask_wr, mask_wdata,
		input use_usb, locked, irq_stat, irq_mask, irq);
	modport sel_mp (input boot_go, hts_key, pin_key, output use_usb, locked);
	modport irq_mp (input irq_set, irq_w1c, mask_wr, mask_wdata, output irq_stat, irq_mask, irq);
endinterface
`default_nettype wire

// ===== logic/transport_select.sv
// Purpose: one-shot choice of host transport
// Assumes: gpio_in synchronous to clk_sys
// Notes:   choice held until reset
`timescale 1ns/10ps
`default_nettype none
`include "usb_sel_cfg.svh"
module transport_select (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [15:0] gpio_in,
	usb_ctl_if.sel_mp        ctl
);
	usb_sel_pkg::sel_state_type state_q, state_d;
	logic                       usb_q, usb_d;
	logic                       pin_hit;

	assign pin_hit = (ctl.pin_key <= `PIN_MAX) && gpio_in[ctl.pin_key[3:0]];

	always_comb begin
		state_d = state_q;
		usb_d   = usb_q;
		unique case (state_q)
			usb_sel_pkg::SEL_WAIT: begin
				if (ctl.boot_go) begin
					state_d = usb_sel_pkg::SEL_LOCKED;
					usb_d   = pin_hit || (ctl.hts_key == `HTS_USB);
				end
			end
			usb_sel_pkg::SEL_LOCKED: begin
				state_d = state_q;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= usb_sel_pkg::SEL_WAIT;
			usb_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			usb_q   <= usb_d;
		end
	end

	assign ctl.use_usb = usb_q;
	assign ctl.locked  = (state_q == usb_sel_pkg::SEL_LOCKED);

	lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctl.locked |=> ctl.locked && $stable(usb_q)) else $error("transport changed after lock");
	pin_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!ctl.locked && ctl.boot_go && pin_hit) |=> usb_q) else $error("pin override ignored");
	key_fallback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!ctl.locked && ctl.boot_go && !pin_hit) |=> (usb_q == ($past(ctl.hts_key) == `HTS_USB)))
		else $error("key not used when pin low");
endmodule
`default_nettype wire

// ===== logic/irq_bank.sv
// Purpose: sticky event bits, mask, one level interrupt
// Assumes: one clock
// Notes:   a set in the clearing cycle wins
`timescale 1ns/10ps
`default_nettype none
`include "usb_sel_cfg.svh"
module irq_bank (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	usb_ctl_if.irq_mp ctl
);
	logic [`IRQ_BITS-1:0] stat_q, stat_d;
	logic [`IRQ_BITS-1:0] mask_q, mask_d;
	logic                 irq_q, irq_d;

	for (genvar i = 0; i < `IRQ_BITS; i++) begin : g_bit
		always_comb begin
			stat_d[i] = ctl.irq_set[i] | (stat_q[i] & ~ctl.irq_w1c[i]);
			mask_d[i] = ctl.mask_wr ? ctl.mask_wdata[i] : mask_q[i];
		end
	end

	always_comb begin
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= 3'h0;
			mask_q <= 3'h0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
		end
	end

	assign ctl.irq_stat = stat_q;
	assign ctl.irq_mask = mask_q;
	assign ctl.irq      = irq_q;

	set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctl.irq_set != 3'h0) |=> ((stat_q & $past(ctl.irq_set)) == $past(ctl.irq_set)))
		else $error("event lost");
endmodule
`default_nettype wire

// ===== logic/usb_host_select_suspend.sv
// Purpose: host transport choice and USB suspend/resume control
// Assumes: AHB-Lite slave, bus_idle synchronous to clk_sys
// Notes:   one upstream port, full speed only
`timescale 1ns/10ps
`default_nettype none
`include "usb_sel_cfg.svh"
module usb_host_select_suspend #(
	parameter int unsigned IDLE_CYCLES     = `IDLE_MIN_CYC,
	parameter int unsigned SUSPEND_LIMIT   = `SUSP_MAX_CYC,
	parameter int unsigned RESUME_CYCLES   = `RESUME_CYC,
	parameter bit          RWAKE_SUPPORTED = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [15:0] gpio_in,
	input  wire logic        bus_idle,
	output logic             pullup_en,
	output logic             core_load_en,
	output logic             extra_load_en,
	output logic             suspended,
	output logic             resume_drive,
	output logic             use_usb,
	output logic             irq
);
	localparam logic [19:0] IDLE_LIM   = 20'(IDLE_CYCLES);
	localparam logic [19:0] RESUME_LIM = 20'(RESUME_CYCLES - 1);
	localparam logic [19:0] SUSP_LIM   = 20'(SUSPEND_LIMIT);

	usb_ctl_if ctl ();

	// ----------------------------------------
	// Bus slave state
	// ----------------------------------------
	logic [13:0] addr_q, addr_d;
	logic        wr_q, wr_d;
	logic        rd_q, rd_d;
	logic        rdy_q, rdy_d;
	logic [31:0] rdata_q, rdata_d;
	logic        accept;
	logic [31:0] rmux;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] hts_q, hts_d;
	logic [15:0] pin_q, pin_d;
	logic        cfg_q, cfg_d;
	logic        rwen_q, rwen_d;
	logic        go_q, go_d;
	logic        wake_q, wake_d;
	logic        lock_seen_q, lock_seen_d;
	logic        wr_word;

	// ----------------------------------------
	// Suspend tracking state
	// ----------------------------------------
	usb_sel_pkg::trk_state_type trk_q, trk_d;
	logic [19:0] cnt_q, cnt_d;
	logic        susp_q, susp_d;
	logic        drv_q, drv_d;
	logic        sevt_q, sevt_d;
	logic        revt_q, revt_d;

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	logic        pull_q, pull_d;
	logic        core_q, core_d;
	logic        extra_q, extra_d;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign accept  = hsel && htrans[1] && hready;
	assign wr_word = wr_q && (addr_q[1:0] == 2'h0);

	always_comb begin
		rmux = 32'h0;
		unique case (addr_q)
			`REG_ADDR(`HTS_IDX):   rmux = {16'h0, hts_q};
			`REG_ADDR(`PIN_IDX):   rmux = {16'h0, pin_q};
			`REG_ADDR(`CTRL_IDX):  rmux = {29'h0, rwen_q, cfg_q, 1'b0};
			`REG_ADDR(`STAT_IDX):  rmux = {28'h0, drv_q, ctl.locked, ctl.use_usb, susp_q};
			`REG_ADDR(`ISTAT_IDX): rmux = {29'h0, ctl.irq_stat};
			`REG_ADDR(`IMASK_IDX): rmux = {29'h0, ctl.irq_mask};
			default:               rmux = 32'h0;
		endcase
	end

	// Reads take one wait state so hrdata leaves a flip-flop
	always_comb begin
		addr_d  = addr_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		rdy_d   = rdy_q;
		rdata_d = rdata_q;
		if (rd_q) begin
			rdata_d = rmux;
			rdy_d   = 1'b1;
		end else if (accept) begin
			addr_d = haddr[13:0];
			wr_d   = hwrite && (hsize == 3'h2);
			rd_d   = !hwrite;
			rdy_d  = hwrite;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_q  <= 14'h0;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			rdy_q   <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			addr_q  <= addr_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
			rdy_q   <= rdy_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_comb begin
		hts_d       = hts_q;
		pin_d       = pin_q;
		cfg_d       = cfg_q;
		rwen_d      = rwen_q;
		go_d        = 1'b0;
		wake_d      = 1'b0;
		lock_seen_d = ctl.locked;
		if (wr_word) begin
			unique case (addr_q)
				`REG_ADDR(`HTS_IDX): hts_d = hwdata[15:0];
				`REG_ADDR(`PIN_IDX): pin_d = hwdata[15:0];
				`REG_ADDR(`CTRL_IDX): begin
					go_d   = hwdata[`CTRL_BOOT];
					cfg_d  = hwdata[`CTRL_CFG];
					rwen_d = hwdata[`CTRL_RWEN];
					wake_d = hwdata[`CTRL_WAKE];
				end
				default: hts_d = hts_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hts_q       <= `HTS_RESET;
			pin_q       <= `PIN_RESET;
			cfg_q       <= 1'b0;
			rwen_q      <= 1'b0;
			go_q        <= 1'b0;
			wake_q      <= 1'b0;
			lock_seen_q <= 1'b0;
		end else begin
			hts_q       <= hts_d;
			pin_q       <= pin_d;
			cfg_q       <= cfg_d;
			rwen_q      <= rwen_d;
			go_q        <= go_d;
			wake_q      <= wake_d;
			lock_seen_q <= lock_seen_d;
		end
	end

	assign ctl.boot_go    = go_q;
	assign ctl.hts_key    = hts_q;
	assign ctl.pin_key    = pin_q;
	assign ctl.irq_set    = {ctl.locked && !lock_seen_q, revt_q, sevt_q};
	assign ctl.irq_w1c    = (wr_word && addr_q == `REG_ADDR(`ISTAT_IDX)) ? hwdata[2:0] : 3'h0;
	assign ctl.mask_wr    = wr_word && (addr_q == `REG_ADDR(`IMASK_IDX));
	assign ctl.mask_wdata = hwdata[2:0];

	transport_select u_sel (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.gpio_in (gpio_in),
		.ctl     (ctl.sel_mp)
	);

	irq_bank u_irq (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ctl     (ctl.irq_mp)
	);

	// ----------------------------------------
	// Suspend tracking
	// ----------------------------------------
	// Idle on the single upstream port is the only input, so global
	// and selective suspend look the same here
	always_comb begin
		trk_d  = trk_q;
		cnt_d  = cnt_q;
		sevt_d = 1'b0;
		revt_d = 1'b0;
		unique case (trk_q)
			usb_sel_pkg::TRK_ACTIVE: begin
				if (!bus_idle) begin
					cnt_d = 20'h0;
				end else if (cnt_q >= IDLE_LIM) begin
					trk_d  = usb_sel_pkg::TRK_SUSPENDED;
					cnt_d  = 20'h0;
					sevt_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 20'h1;
				end
			end
			usb_sel_pkg::TRK_SUSPENDED: begin
				if (!bus_idle) begin
					trk_d  = usb_sel_pkg::TRK_ACTIVE;
					revt_d = 1'b1;
				end else if (wake_q && RWAKE_SUPPORTED && rwen_q) begin
					trk_d = usb_sel_pkg::TRK_WAKE;
					cnt_d = 20'h0;
				end
			end
			usb_sel_pkg::TRK_WAKE: begin
				// Own resume drive masks the line, so it is not watched here
				if (cnt_q >= RESUME_LIM) begin
					trk_d = usb_sel_pkg::TRK_ACTIVE;
					cnt_d = 20'h0;
				end else begin
					cnt_d = cnt_q + 20'h1;
				end
			end
			default: begin
				trk_d = usb_sel_pkg::TRK_ACTIVE;
				cnt_d = 20'h0;
			end
		endcase
		susp_d = (trk_d == usb_sel_pkg::TRK_SUSPENDED);
		drv_d  = (trk_d == usb_sel_pkg::TRK_WAKE);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trk_q  <= usb_sel_pkg::TRK_ACTIVE;
			cnt_q  <= 20'h0;
			susp_q <= 1'b0;
			drv_q  <= 1'b0;
			sevt_q <= 1'b0;
			revt_q <= 1'b0;
		end else begin
			trk_q  <= trk_d;
			cnt_q  <= cnt_d;
			susp_q <= susp_d;
			drv_q  <= drv_d;
			sevt_q <= sevt_d;
			revt_q <= revt_d;
		end
	end

	// ----------------------------------------
	// Power and pull-up control
	// ----------------------------------------
	// Loads follow the next state so they drop with the suspend flag
	always_comb begin
		pull_d  = ctl.locked && ctl.use_usb;
		core_d  = !susp_d;
		extra_d = cfg_q && !susp_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pull_q  <= 1'b0;
			core_q  <= 1'b0;
			extra_q <= 1'b0;
		end else begin
			pull_q  <= pull_d;
			core_q  <= core_d;
			extra_q <= extra_d;
		end
	end

	assign hreadyout     = rdy_q;
	assign hresp         = 1'b0;
	assign hrdata        = rdata_q;
	assign pullup_en     = pull_q;
	assign core_load_en  = core_q;
	assign extra_load_en = extra_q;
	assign suspended     = susp_q;
	assign resume_drive  = drv_q;
	assign use_usb       = ctl.use_usb;
	assign irq           = ctl.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [19:0] idle_run_q, idle_run_d;

	always_comb begin
		idle_run_d = idle_run_q;
		if (!bus_idle || trk_q != usb_sel_pkg::TRK_ACTIVE) begin
			idle_run_d = 20'h0;
		end else if (idle_run_q != 20'hFFFFF) begin
			idle_run_d = idle_run_q + 20'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idle_run_q <= 20'h0;
		end else begin
			idle_run_q <= idle_run_d;
		end
	end

	idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trk_q == usb_sel_pkg::TRK_ACTIVE && bus_idle && cnt_q == IDLE_LIM) |=> susp_q && sevt_q)
		else $error("suspend not entered after idle");
	no_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(susp_q) |-> $past(idle_run_q) >= IDLE_LIM) else $error("suspend entered early");
	suspend_deadline_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		idle_run_q <= SUSP_LIM) else $error("suspend deadline missed");
	activity_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trk_q == usb_sel_pkg::TRK_ACTIVE && !bus_idle) |=> cnt_q == 20'h0 && !susp_q)
		else $error("activity did not restart idle timing");
	bus_resume_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(susp_q && !bus_idle) |=> !susp_q && revt_q) else $error("no resume on bus activity");
	wake_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(drv_q) |-> $past(rwen_q) && RWAKE_SUPPORTED && $past(susp_q))
		else $error("remote wakeup not enabled");
	pullup_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(susp_q && pull_q) |=> pull_q) else $error("pull-up dropped in suspend");
	suspend_loads_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		susp_q |-> !core_q && !extra_q) else $error("loads on in suspend");
	config_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		extra_q |-> $past(cfg_q)) else $error("extra load before configuration");
	read_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(accept && !hwrite && !rd_q) |=> !rdy_q ##1 rdy_q) else $error("read wait state wrong");
endmodule
`default_nettype wire

// ===== testbench/upstream_hub_model.sv
// Purpose: upstream hub port as seen by the device
// Assumes: one clock, line state reduced to an idle flag
// Notes:   keeps frame traffic going unless the port is suspended
`timescale 1ns/10ps
`default_nettype none
module upstream_hub_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic suspend_req,
	input  wire logic resume_drive,
	output logic      bus_idle
);
	// ----------------------------------------
	// Port state
	// ----------------------------------------
	logic wake_seen_q;
	logic tog_q;
	logic req_q;

	// Traffic toggles every cycle, so no idle run grows long while suspend_req is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_seen_q <= 1'b0;
			tog_q       <= 1'b0;
			req_q       <= 1'b0;
			bus_idle    <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
			req_q <= suspend_req;
			if (resume_drive) begin
				wake_seen_q <= 1'b1;
			end else if (!suspend_req) begin
				wake_seen_q <= 1'b0;
			end
			// Suspended port blocks all traffic to the segment
			if (suspend_req && !wake_seen_q && !resume_drive) begin
				bus_idle <= 1'b1;
			end else if (req_q && !suspend_req) begin
				// Port release opens with resume signalling, so the line is never idle first
				bus_idle <= 1'b0;
			end else begin
				bus_idle <= tog_q;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/usb_host_select_suspend_tb.sv
// Purpose: self-checking bench for transport choice and suspend control
// Assumes: short idle and resume counts set by parameter
// Notes:   single AHB master, hub model on the line side
`timescale 1ns/10ps
`default_nettype none
`include "usb_sel_cfg.svh"
module usb_host_select_suspend_tb;
	// ----------------------------------------
	// Setup
	// ----------------------------------------
	localparam int IDLE = 20;
	localparam int SLIM = 40;
	localparam int RES  = 8;
	localparam logic [31:0] A_HTS  = 32'(`REG_ADDR(`HTS_IDX));
	localparam logic [31:0] A_PIN  = 32'(`REG_ADDR(`PIN_IDX));
	localparam logic [31:0] A_CTRL = 32'(`REG_ADDR(`CTRL_IDX));
	localparam logic [31:0] A_STAT = 32'(`REG_ADDR(`STAT_IDX));
	localparam logic [31:0] A_IST  = 32'(`REG_ADDR(`ISTAT_IDX));
	localparam logic [31:0] A_IMSK = 32'(`REG_ADDR(`IMASK_IDX));
	localparam logic [31:0] A_NONE = 32'h0000_0100;
	localparam logic [15:0] PINS [7] = '{16'h0005, 16'h0005, 16'h0005, 16'h000F, 16'h0010,
		16'hFFFF, 16'hFFFF};
	localparam logic [15:0] GPIOS [7] = '{16'h0020, 16'hFFDF, 16'hFFDF, 16'h8000, 16'hFFFF,
		16'hFFFF, 16'h0000};
	localparam logic [15:0] KEYS [7] = '{16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0001,
		16'h0001, 16'h0002};
	localparam logic EXPS [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	logic        clk_sys;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [15:0] gpio_in;
	logic        bus_idle;
	logic        suspend_req;
	logic        pullup_en;
	logic        core_load_en;
	logic        extra_load_en;
	logic        suspended;
	logic        resume_drive;
	logic        use_usb;
	logic        irq;
	logic [31:0] rd;
	int          bad_count;
	int          compares;
	int          n;
	logic [2:0]  sz;

	assign hready = hreadyout;

	usb_host_select_suspend #(.IDLE_CYCLES(IDLE), .SUSPEND_LIMIT(SLIM), .RESUME_CYCLES(RES)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio_in),
		.bus_idle(bus_idle), .pullup_en(pullup_en), .core_load_en(core_load_en),
		.extra_load_en(extra_load_en), .suspended(suspended), .resume_drive(resume_drive),
		.use_usb(use_usb), .irq(irq));

	upstream_hub_model u_hub (.clk_sys(clk_sys), .rst_n(rst_n), .suspend_req(suspend_req),
		.resume_drive(resume_drive), .bus_idle(bus_idle));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	// Address phase held until hready, then data phase until hready again
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= sz;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr32(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		check(name, rd, exp);
		check("hresp", 32'(hresp), 32'h0000_0000);
	endtask

	task automatic do_reset;
		rst_n       <= 1'b0;
		suspend_req <= 1'b0;
		cyc(10);
		rst_n <= 1'b1;
		cyc(1);
	endtask

	task automatic boot(input logic [15:0] pin, input logic [15:0] g, input logic [15:0] key);
		do_reset();
		gpio_in <= g;
		wr32(A_PIN, 32'(pin));
		wr32(A_HTS, 32'(key));
		wr32(A_CTRL, 32'h0000_0001);
		cyc(3);
	endtask

	// Bounded wait on the idle run, count of edges returned in n
	task automatic enter_susp;
		suspend_req <= 1'b1;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (suspended !== 1'b1 && n < 200);
		check("susp_reached", 32'(suspended), 32'h0000_0001);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		do_reset();
		rd_chk("hts_reset", A_HTS, 32'h0000_0001);
		rd_chk("pin_reset", A_PIN, 32'h0000_FFFF);
		rd_chk("imask_reset", A_IMSK, 32'h0000_0000);
		wr32(A_NONE, 32'hFFFF_FFFF);
		rd_chk("unmapped", A_NONE, 32'h0000_0000);
		wr32(A_HTS, 32'h0000_0002);
		rd_chk("hts_rw", A_HTS, 32'h0000_0002);
		// Non-word writes are refused and leave the key alone
		sz = 3'h1;
		wr32(A_HTS, 32'h0000_0001);
		sz = 3'h2;
		rd_chk("hts_half", A_HTS, 32'h0000_0002);
		check("usb_pre_boot", 32'(use_usb), 32'h0000_0000);
		check("pullup_pre_boot", 32'(pullup_en), 32'h0000_0000);
	endtask

	// Second go with flipped pin and key must leave the choice alone
	task automatic t_boot_all;
		for (int i = 0; i < 7; i++) begin
			boot(PINS[i], GPIOS[i], KEYS[i]);
			check("use_usb", 32'(use_usb), 32'(EXPS[i]));
			check("pullup", 32'(pullup_en), 32'(EXPS[i]));
			rd_chk("status", A_STAT, 32'h0000_0004 | (32'(EXPS[i]) << 1));
			gpio_in <= ~GPIOS[i];
			wr32(A_HTS, 32'(KEYS[i] ^ 16'h0003));
			wr32(A_CTRL, 32'h0000_0001);
			cyc(3);
			check("use_usb_held", 32'(use_usb), 32'(EXPS[i]));
		end
	endtask

	task automatic t_suspend;
		boot(16'h0005, 16'h0020, 16'h0001);
		check("extra_unconf", 32'(extra_load_en), 32'h0000_0000);
		wr32(A_CTRL, 32'h0000_0002);
		cyc(2);
		check("extra_conf", 32'(extra_load_en), 32'h0000_0001);
		n = 0;
		repeat (2) begin
			suspend_req <= 1'b1;
			repeat (IDLE - 3) begin
				cyc(1);
				if (suspended === 1'b1) n++;
			end
			suspend_req <= 1'b0;
			cyc(4);
		end
		check("no_early_susp", 32'(n), 32'h0000_0000);
		enter_susp();
		check("susp_min", 32'(n > IDLE), 32'h0000_0001);
		check("susp_max", 32'(n <= IDLE + 4), 32'h0000_0001);
		check("susp_limit", 32'(n <= SLIM), 32'h0000_0001);
		check("pullup_susp", 32'(pullup_en), 32'h0000_0001);
		check("core_susp", 32'(core_load_en), 32'h0000_0000);
		check("extra_susp", 32'(extra_load_en), 32'h0000_0000);
		rd_chk("status_susp", A_STAT, 32'h0000_0007);
		rd_chk("istat_susp", A_IST, 32'h0000_0005);
		check("irq_masked", 32'(irq), 32'h0000_0000);
		wr32(A_IMSK, 32'h0000_0001);
		cyc(2);
		check("irq_on", 32'(irq), 32'h0000_0001);
		wr32(A_IST, 32'h0000_0005);
		cyc(2);
		check("irq_off", 32'(irq), 32'h0000_0000);
		rd_chk("istat_clr", A_IST, 32'h0000_0000);
		suspend_req <= 1'b0;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (suspended !== 1'b0 && n < 20);
		check("resume_fast", 32'(n <= 3), 32'h0000_0001);
		cyc(2);
		rd_chk("istat_res", A_IST, 32'h0000_0002);
		check("core_back", 32'(core_load_en), 32'h0000_0001);
		check("extra_back", 32'(extra_load_en), 32'h0000_0001);
		wr32(A_IST, 32'h0000_0002);
	endtask

	// Wake request without the enable bit must be refused
	task automatic t_wake;
		enter_susp();
		wr32(A_CTRL, 32'h0000_000A);
		cyc(6);
		check("wake_refused", 32'(resume_drive), 32'h0000_0000);
		check("still_susp", 32'(suspended), 32'h0000_0001);
		wr32(A_CTRL, 32'h0000_000E);
		n = 0;
		while (resume_drive !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		check("wake_start", 32'(n <= 3), 32'h0000_0001);
		n = 0;
		while (resume_drive === 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		check("wake_len", 32'(n >= RES - 1 && n <= RES + 1), 32'h0000_0001);
		cyc(3);
		check("wake_active", 32'(suspended), 32'h0000_0000);
		suspend_req <= 1'b0;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n       = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h0000_0000;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		sz          = 3'h2;
		hwdata      = 32'h0000_0000;
		gpio_in     = 16'h0000;
		suspend_req = 1'b0;
		bad_count   = 0;
		compares    = 0;
		t_regs();
		t_boot_all();
		t_suspend();
		t_wake();
		finish_test();
	end

	// Whole run is a few hundred cycles, so this margin only trips on a hang
	initial begin
		cyc(30000);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
